// >>> core/ppbl_top.sv
// Purpose: Port latches, external bus cycle engine, timer output, interrupt intake
// Assumes: clk_sys 20 MHz, AXI4-Lite slave, software drives each bus cycle
// Notes:   Software issues bus cycles one at a time
// Operation
// - Port A latch holds software written byte
// - Reset drives all port A lines low
// - Port B line floats when input or reset
// - Direction bit zero output, one input
// - Reset sets all direction bits to one
// - Port B read mixes pins and latches
// - Port B write changes only output bits
// - Latch drives pin when switched to output
// - Port B latches hold until write/reset
// - Port C six-bit input, low bits
// - Strobes pulse during access, else float
// - Timer square wave, half count period
// - Data bus floats on input, halt, reset
// - Address bus shows cycle address, unlatched
// - Export shows pair on ninth clock only
// - Fetch flag covers T1 to T3
// - Low wait request at T2 adds waits
// - Level interrupt requests while high
// - Edge interrupt requests on rising edge
// - Priority level, then timer, then edge
// - Interrupt pins sampled at fixed interval
`timescale 1ns/1ps
`default_nettype none
`include "ppbl_regs.svh"
module ppbl_top (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [7:0]       output_port_pins,
  input  wire logic [7:0]  bidir_port_pins_in,
  output logic [7:0]       bidir_port_pins_out,
  output logic [7:0]       bidir_port_pins_oe,
  input  wire logic [5:0]  input_port_pins,
  output logic             wr_strobe_n_out,
  output logic             wr_strobe_n_oe,
  output logic             rd_strobe_n_out,
  output logic             rd_strobe_n_oe,
  output logic             timer_square_out,
  input  wire logic [7:0]  ext_data_bus_in,
  output logic [7:0]       ext_data_bus_out,
  output logic             ext_data_bus_oe,
  output logic [15:0]      ext_address_bus,
  output logic             first_fetch_cycle_flag,
  input  wire logic        wait_request_n,
  input  wire logic        level_irq_input,
  input  wire logic        edge_irq_input,
  output logic             irq_request,
  output logic [1:0]       irq_source
);
  ppbl_pkg::ppbl_state_s s_ff, nxt_s;
  logic                  lvl_req;
  logic                  edge_rise;
  logic                  wr_fire;
  logic                  strobe_mc;
  logic                  strobe_ph;
  logic                  rd_act;
  logic                  wr_act;
  logic [7:0]            pb_rd;
  ppbl_pkg::ppbl_src_e   src;

  function automatic logic [7:0] ppbl_lane(input logic [7:0] old, input logic [7:0] dat,
                                           input logic en);
    return en ? dat : old;
  endfunction : ppbl_lane

  function automatic logic ppbl_mapped(input logic [7:0] a);
    case (a)
      `PPBL_OFF_PORTA, `PPBL_OFF_PORTB, `PPBL_OFF_PBDIR, `PPBL_OFF_PORTC,
      `PPBL_OFF_ADDR, `PPBL_OFF_WDATA, `PPBL_OFF_PAIR, `PPBL_OFF_CMD,
      `PPBL_OFF_CTRL, `PPBL_OFF_IRQ: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : ppbl_mapped

  function automatic ppbl_pkg::ppbl_src_e ppbl_prio(input logic l, input logic t,
                                                    input logic e);
    if (l) return ppbl_pkg::PPBL_SRC_LEVEL;
    if (t) return ppbl_pkg::PPBL_SRC_TIMER;
    if (e) return ppbl_pkg::PPBL_SRC_EDGE;
    return ppbl_pkg::PPBL_SRC_NONE;
  endfunction : ppbl_prio

  ppbl_irq_sampler u_smp (
    .clk_sys         (clk_sys),
    .reset_n         (reset_n),
    .level_irq_input (level_irq_input),
    .edge_irq_input  (edge_irq_input),
    .level_req       (lvl_req),
    .edge_rise       (edge_rise)
  );

  assign wr_fire = s_ff.aw_ok && s_ff.w_ok;
  // The internal third cycle of an export has no strobe
  assign strobe_mc = (s_ff.kind != ppbl_pkg::PPBL_K_NONE) &&
                     !(s_ff.kind == ppbl_pkg::PPBL_K_EXPORT && s_ff.mc == `PPBL_MC_EXPORT);
  assign strobe_ph = (s_ff.st == ppbl_pkg::PPBL_T2) || (s_ff.st == ppbl_pkg::PPBL_TWAIT) ||
                     (s_ff.st == ppbl_pkg::PPBL_T3);
  assign rd_act = strobe_ph && strobe_mc && (s_ff.kind != ppbl_pkg::PPBL_K_WRITE);
  assign wr_act = strobe_ph && strobe_mc && (s_ff.kind == ppbl_pkg::PPBL_K_WRITE);
  assign pb_rd = (s_ff.pb_s2 & s_ff.pbdir) | (s_ff.pbo & ~s_ff.pbdir);
  assign src = ppbl_prio(lvl_req, s_ff.tpend, s_ff.epend);

  always_comb begin
    nxt_s = s_ff;
    nxt_s.pb_s1 = bidir_port_pins_in;
    nxt_s.pb_s2 = s_ff.pb_s1;
    nxt_s.pc_s1 = input_port_pins;
    nxt_s.pc_s2 = s_ff.pc_s1;
    nxt_s.db_s1 = ext_data_bus_in;
    nxt_s.db_s2 = s_ff.db_s1;
    nxt_s.wt_s1 = wait_request_n;
    nxt_s.wt_s2 = s_ff.wt_s1;
    if (s_ff.bv && s_axi_bready) begin
      nxt_s.bv = 1'b0;
    end
    if (s_ff.rv && s_axi_rready) begin
      nxt_s.rv = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_s.aw_ok = 1'b1;
      nxt_s.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_s.w_ok = 1'b1;
      nxt_s.wd = s_axi_wdata;
      nxt_s.ws = s_axi_wstrb;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_s.rv = 1'b1;
      nxt_s.rr = ppbl_mapped(s_axi_araddr) ? `PPBL_RESP_OKAY : `PPBL_RESP_SLVERR;
      nxt_s.rd = 32'h0000_0000;
      case (s_axi_araddr)
        `PPBL_OFF_PORTA: nxt_s.rd[7:0] = s_ff.porta;
        `PPBL_OFF_PORTB: nxt_s.rd[7:0] = pb_rd;
        `PPBL_OFF_PBDIR: nxt_s.rd[7:0] = s_ff.pbdir;
        `PPBL_OFF_PORTC: nxt_s.rd[5:0] = s_ff.pc_s2;
        `PPBL_OFF_ADDR:  nxt_s.rd[15:0] = s_ff.addr;
        `PPBL_OFF_WDATA: nxt_s.rd[7:0] = s_ff.wdat;
        `PPBL_OFF_PAIR:  nxt_s.rd[15:0] = s_ff.pair;
        `PPBL_OFF_CMD:   nxt_s.rd[15:0] = {s_ff.rdat, 7'h00, s_ff.st != ppbl_pkg::PPBL_IDLE};
        `PPBL_OFF_CTRL:  nxt_s.rd[15:0] = {s_ff.tq, 6'h00, s_ff.tmr_en, s_ff.halt};
        `PPBL_OFF_IRQ:   nxt_s.rd[5:0] = {src, 1'b0, s_ff.epend, s_ff.tpend, lvl_req};
        default:         nxt_s.rd = 32'h0000_0000;
      endcase
    end
    if (wr_fire) begin
      nxt_s.aw_ok = 1'b0;
      nxt_s.w_ok = 1'b0;
      nxt_s.bv = 1'b1;
      nxt_s.br = ppbl_mapped(s_ff.awa) ? `PPBL_RESP_OKAY : `PPBL_RESP_SLVERR;
      case (s_ff.awa)
        `PPBL_OFF_PORTA: nxt_s.porta = ppbl_lane(s_ff.porta, s_ff.wd[7:0], s_ff.ws[0]);
        `PPBL_OFF_PORTB: begin
          if (s_ff.ws[0]) begin
            nxt_s.pbo = (s_ff.wd[7:0] & ~s_ff.pbdir) | (s_ff.pbo & s_ff.pbdir);
          end
        end
        `PPBL_OFF_PBDIR: nxt_s.pbdir = ppbl_lane(s_ff.pbdir, s_ff.wd[7:0], s_ff.ws[0]);
        `PPBL_OFF_ADDR: begin
          nxt_s.addr[7:0] = ppbl_lane(s_ff.addr[7:0], s_ff.wd[7:0], s_ff.ws[0]);
          nxt_s.addr[15:8] = ppbl_lane(s_ff.addr[15:8], s_ff.wd[15:8], s_ff.ws[1]);
        end
        `PPBL_OFF_WDATA: nxt_s.wdat = ppbl_lane(s_ff.wdat, s_ff.wd[7:0], s_ff.ws[0]);
        `PPBL_OFF_PAIR: begin
          nxt_s.pair[7:0] = ppbl_lane(s_ff.pair[7:0], s_ff.wd[7:0], s_ff.ws[0]);
          nxt_s.pair[15:8] = ppbl_lane(s_ff.pair[15:8], s_ff.wd[15:8], s_ff.ws[1]);
        end
        `PPBL_OFF_CMD: begin
          // Commands during a cycle or halt are dropped, not queued
          if (s_ff.ws[0] && s_ff.st == ppbl_pkg::PPBL_IDLE && !s_ff.halt &&
              s_ff.wd[2:0] != 3'h0 && s_ff.wd[2:0] <= 3'h4) begin
            nxt_s.kind = ppbl_pkg::ppbl_kind_e'(s_ff.wd[2:0]);
            nxt_s.mc = 2'h0;
            nxt_s.iclk = 5'h00;
            nxt_s.st = ppbl_pkg::PPBL_T1;
          end
        end
        `PPBL_OFF_CTRL: begin
          if (s_ff.ws[0]) begin
            nxt_s.halt = s_ff.wd[`PPBL_CTRL_HALT];
            nxt_s.tmr_en = s_ff.wd[`PPBL_CTRL_TEN];
          end
          nxt_s.tq = ppbl_lane(s_ff.tq, s_ff.wd[15:8], s_ff.ws[1]);
        end
        `PPBL_OFF_IRQ: begin
          if (s_ff.ws[0] && s_ff.wd[`PPBL_STAT_TPEND]) begin
            nxt_s.tpend = 1'b0;
          end
          if (s_ff.ws[0] && s_ff.wd[`PPBL_STAT_EPEND]) begin
            nxt_s.epend = 1'b0;
          end
        end
        default: nxt_s.br = `PPBL_RESP_SLVERR;
      endcase
    end
    if (s_ff.st != ppbl_pkg::PPBL_IDLE && s_ff.st != ppbl_pkg::PPBL_TWAIT) begin
      nxt_s.iclk = s_ff.iclk + 5'h01;
    end
    case (s_ff.st)
      ppbl_pkg::PPBL_IDLE: begin
        if (nxt_s.st == ppbl_pkg::PPBL_IDLE) begin
          nxt_s.kind = ppbl_pkg::PPBL_K_NONE;
        end
      end
      ppbl_pkg::PPBL_T1: nxt_s.st = ppbl_pkg::PPBL_T2;
      ppbl_pkg::PPBL_T2: begin
        // Wait is seen through the synchroniser, two clocks behind the pin
        if (strobe_mc && !s_ff.wt_s2) begin
          nxt_s.st = ppbl_pkg::PPBL_TWAIT;
        end else begin
          nxt_s.st = ppbl_pkg::PPBL_T3;
        end
      end
      ppbl_pkg::PPBL_TWAIT: begin
        if (s_ff.wt_s2) begin
          nxt_s.st = ppbl_pkg::PPBL_T3;
        end
      end
      ppbl_pkg::PPBL_T3: nxt_s.st = ppbl_pkg::PPBL_T4;
      ppbl_pkg::PPBL_T4: begin
        // Synchroniser lag: this byte left the pins while the strobe was still low
        if (strobe_mc && s_ff.kind != ppbl_pkg::PPBL_K_WRITE) begin
          nxt_s.rdat = s_ff.db_s2;
        end
        if (s_ff.kind == ppbl_pkg::PPBL_K_EXPORT && s_ff.mc != `PPBL_MC_EXPORT) begin
          nxt_s.mc = s_ff.mc + 2'h1;
          nxt_s.st = ppbl_pkg::PPBL_T1;
        end else begin
          nxt_s.st = ppbl_pkg::PPBL_IDLE;
        end
      end
      default: nxt_s.st = ppbl_pkg::PPBL_IDLE;
    endcase
    // Square period is two quarters, so it runs at half the full count time
    if (!s_ff.tmr_en) begin
      nxt_s.tcnt = 8'h00;
      nxt_s.tph = 2'h0;
    end else if (s_ff.tcnt == s_ff.tq) begin
      nxt_s.tcnt = 8'h00;
      nxt_s.tsq = !s_ff.tsq;
      nxt_s.tph = s_ff.tph + 2'h1;
      if (s_ff.tph == 2'h3) begin
        nxt_s.tpend = 1'b1;
      end
    end else begin
      nxt_s.tcnt = s_ff.tcnt + 8'h01;
    end
    if (edge_rise) begin
      nxt_s.epend = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_ff <= '0;
      s_ff.porta <= `PPBL_RST_PORTA;
      s_ff.pbdir <= `PPBL_RST_PBDIR;
      s_ff.wt_s1 <= 1'b1;
      s_ff.wt_s2 <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign s_axi_awready = !s_ff.aw_ok && !s_ff.bv;
  assign s_axi_wready = !s_ff.w_ok && !s_ff.bv;
  assign s_axi_bvalid = s_ff.bv;
  assign s_axi_bresp = s_ff.br;
  assign s_axi_arready = !s_ff.rv;
  assign s_axi_rvalid = s_ff.rv;
  assign s_axi_rdata = s_ff.rd;
  assign s_axi_rresp = s_ff.rr;
  assign output_port_pins = s_ff.porta;
  assign bidir_port_pins_out = s_ff.pbo;
  assign bidir_port_pins_oe = ~s_ff.pbdir;
  assign wr_strobe_n_out = 1'b0;
  assign wr_strobe_n_oe = wr_act;
  assign rd_strobe_n_out = 1'b0;
  assign rd_strobe_n_oe = rd_act;
  assign timer_square_out = s_ff.tsq;
  assign ext_data_bus_out = s_ff.wdat;
  assign ext_data_bus_oe = (s_ff.kind == ppbl_pkg::PPBL_K_WRITE) && !s_ff.halt &&
                           (s_ff.st != ppbl_pkg::PPBL_IDLE);
  assign first_fetch_cycle_flag = (strobe_ph || s_ff.st == ppbl_pkg::PPBL_T1) &&
                                  s_ff.mc == 2'h0 &&
                                  (s_ff.kind == ppbl_pkg::PPBL_K_FETCH ||
                                   s_ff.kind == ppbl_pkg::PPBL_K_EXPORT);
  assign irq_request = src != ppbl_pkg::PPBL_SRC_NONE;
  assign irq_source = src;

  always_comb begin
    ext_address_bus = 16'h0000;
    if (s_ff.st != ppbl_pkg::PPBL_IDLE) begin
      if (s_ff.kind == ppbl_pkg::PPBL_K_EXPORT && s_ff.mc == `PPBL_MC_EXPORT &&
          s_ff.st == ppbl_pkg::PPBL_T1) begin
        ext_address_bus = s_ff.pair;
      end else begin
        ext_address_bus = s_ff.addr + {14'h0000, s_ff.mc};
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence seq_pb_dir_write;
    wr_fire && s_ff.awa == `PPBL_OFF_PBDIR && s_ff.ws[0];
  endsequence
  sequence seq_pb_data_write;
    wr_fire && s_ff.awa == `PPBL_OFF_PORTB && s_ff.ws[0];
  endsequence

  a_porta_hold: assert property (
    !(wr_fire && s_ff.awa == `PPBL_OFF_PORTA) |=> $stable(output_port_pins))
    else $error("port A changed without a write");
  a_pb_dir_drive: assert property (
    seq_pb_dir_write |=> bidir_port_pins_oe == ~$past(s_ff.wd[7:0]))
    else $error("port B enables do not follow direction write");
  a_pb_input_keep: assert property (
    seq_pb_data_write |=> (s_ff.pbo & s_ff.pbdir) == ($past(s_ff.pbo) & s_ff.pbdir))
    else $error("port B write touched an input latch");
  a_pb_read_mix: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `PPBL_OFF_PORTB
    |=> s_axi_rdata[7:0] == (($past(s_ff.pb_s2) & $past(s_ff.pbdir)) |
                             ($past(s_ff.pbo) & ~$past(s_ff.pbdir))))
    else $error("port B read value wrong");
  a_export_ninth: assert property (
    s_ff.kind == ppbl_pkg::PPBL_K_EXPORT && ext_address_bus == s_ff.pair &&
    ext_address_bus != s_ff.addr + {14'h0000, s_ff.mc} && s_ff.st != ppbl_pkg::PPBL_IDLE
    |-> s_ff.iclk + 5'h01 == `PPBL_EXPORT_CLK ##1 ext_address_bus == s_ff.addr + 16'h0002)
    else $error("pair shown outside the ninth clock");
  a_fetch_span: assert property (
    $rose(first_fetch_cycle_flag) |-> s_ff.st == ppbl_pkg::PPBL_T1
    ##1 first_fetch_cycle_flag && s_ff.st == ppbl_pkg::PPBL_T2)
    else $error("fetch flag span wrong");
  a_fetch_end: assert property (
    $fell(first_fetch_cycle_flag) |-> $past(s_ff.st) == ppbl_pkg::PPBL_T3 &&
    s_ff.st == ppbl_pkg::PPBL_T4)
    else $error("fetch flag ended outside T3");
  a_wait_stretch: assert property (
    s_ff.st == ppbl_pkg::PPBL_T2 && strobe_mc && !s_ff.wt_s2
    |=> s_ff.st == ppbl_pkg::PPBL_TWAIT && (rd_strobe_n_oe || wr_strobe_n_oe))
    else $error("no wait state inserted");
  a_db_release: assert property (
    ext_data_bus_oe |-> s_ff.kind == ppbl_pkg::PPBL_K_WRITE && !rd_strobe_n_oe && !s_ff.halt)
    else $error("data bus driven outside a write");
  a_timer_toggle: assert property (
    s_ff.tmr_en && s_ff.tcnt == s_ff.tq |=> timer_square_out != $past(timer_square_out))
    else $error("timer output missed a toggle");
  a_edge_set_wins: assert property (
    edge_rise |=> s_ff.epend ##0 irq_request)
    else $error("edge request lost");
  a_irq_priority: assert property (
    (lvl_req |-> irq_source == ppbl_pkg::PPBL_SRC_LEVEL) and
    (!lvl_req && s_ff.tpend |-> irq_source == ppbl_pkg::PPBL_SRC_TIMER) and
    (!lvl_req && !s_ff.tpend && s_ff.epend |-> irq_source == ppbl_pkg::PPBL_SRC_EDGE))
    else $error("interrupt priority wrong");
endmodule : ppbl_top
`default_nettype wire

// >>> include/ppbl_regs.svh
// Purpose: Register offsets, fields, reset values and timing for the port and bus pin logic
// Assumes: 8-bit AXI4-Lite byte addresses
// Notes:   Definitions only
`ifndef PPBL_REGS_SVH
`define PPBL_REGS_SVH
`define PPBL_OFF_PORTA    8'h00
`define PPBL_OFF_PORTB    8'h04
`define PPBL_OFF_PBDIR    8'h08
`define PPBL_OFF_PORTC    8'h0C
`define PPBL_OFF_ADDR     8'h10
`define PPBL_OFF_WDATA    8'h14
`define PPBL_OFF_PAIR     8'h18
`define PPBL_OFF_CMD      8'h1C
`define PPBL_OFF_CTRL     8'h20
`define PPBL_OFF_IRQ      8'h24
`define PPBL_RST_PORTA    8'h00
`define PPBL_RST_PBDIR    8'hFF
`define PPBL_CTRL_HALT    0
`define PPBL_CTRL_TEN     1
`define PPBL_STAT_TPEND   1
`define PPBL_STAT_EPEND   2
`define PPBL_MC_EXPORT    2'h2
`define PPBL_EXPORT_CLK   5'h09
`define PPBL_RESP_OKAY    2'h0
`define PPBL_RESP_SLVERR  2'h2
`define PPBL_CLK_NS       50
`define PPBL_SAMPLE_NS    1000
`define PPBL_SAMPLE_CYC   ((`PPBL_SAMPLE_NS) / (`PPBL_CLK_NS))
`endif

// >>> include/ppbl_pkg.sv
// Purpose: Types for the port and bus pin logic
// Assumes: Nothing
// Notes:   State of each module is one packed struct
`default_nettype none
package ppbl_pkg;
  typedef enum logic [2:0] {
    PPBL_IDLE  = 3'h0,
    PPBL_T1    = 3'h1,
    PPBL_T2    = 3'h2,
    PPBL_TWAIT = 3'h3,
    PPBL_T3    = 3'h4,
    PPBL_T4    = 3'h5
  } ppbl_bus_e;
  typedef enum logic [2:0] {
    PPBL_K_NONE   = 3'h0,
    PPBL_K_READ   = 3'h1,
    PPBL_K_WRITE  = 3'h2,
    PPBL_K_FETCH  = 3'h3,
    PPBL_K_EXPORT = 3'h4
  } ppbl_kind_e;
  typedef enum logic [1:0] {
    PPBL_SRC_NONE  = 2'h0,
    PPBL_SRC_LEVEL = 2'h1,
    PPBL_SRC_TIMER = 2'h2,
    PPBL_SRC_EDGE  = 2'h3
  } ppbl_src_e;
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [4:0] tick;
    logic       lvl;
    logic       edg;
    logic       rise;
  } ppbl_smp_s;
  typedef struct packed {
    logic [7:0]  porta;
    logic [7:0]  pbo;
    logic [7:0]  pbdir;
    logic [7:0]  pb_s1;
    logic [7:0]  pb_s2;
    logic [5:0]  pc_s1;
    logic [5:0]  pc_s2;
    logic [7:0]  db_s1;
    logic [7:0]  db_s2;
    logic        wt_s1;
    logic        wt_s2;
    logic [15:0] addr;
    logic [7:0]  wdat;
    logic [15:0] pair;
    logic [7:0]  rdat;
    logic        halt;
    logic        tmr_en;
    logic [7:0]  tq;
    logic [7:0]  tcnt;
    logic [1:0]  tph;
    logic        tsq;
    logic        tpend;
    logic        epend;
    ppbl_bus_e   st;
    ppbl_kind_e  kind;
    logic [1:0]  mc;
    logic [4:0]  iclk;
    logic        aw_ok;
    logic        w_ok;
    logic [7:0]  awa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bv;
    logic [1:0]  br;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
  } ppbl_state_s;
endpackage : ppbl_pkg
`default_nettype wire

// >>> core/ppbl_irq_sampler.sv
// Purpose: Synchronise and periodically sample the two interrupt pins
// Assumes: clk_sys at 20 MHz
// Notes:   Pulses shorter than one sample interval may be missed by design
`timescale 1ns/1ps
`default_nettype none
`include "ppbl_regs.svh"
module ppbl_irq_sampler (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic level_irq_input,
  input  wire logic edge_irq_input,
  output logic      level_req,
  output logic      edge_rise
);
  localparam logic [4:0] LAST = 5'(`PPBL_SAMPLE_CYC - 1);
  ppbl_pkg::ppbl_smp_s s_ff, nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.s1 = {edge_irq_input, level_irq_input};
    nxt_s.s2 = s_ff.s1;
    nxt_s.rise = 1'b0;
    if (s_ff.tick == LAST) begin
      nxt_s.tick = 5'h00;
      nxt_s.lvl = s_ff.s2[0];
      nxt_s.edg = s_ff.s2[1];
      nxt_s.rise = s_ff.s2[1] && !s_ff.edg;
    end else begin
      nxt_s.tick = s_ff.tick + 5'h01;
    end
  end

  // Edge history starts high so a line already high at reset is no request
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_ff <= '{s1: 2'h0, s2: 2'h0, tick: 5'h00, lvl: 1'b0, edg: 1'b1, rise: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign level_req = s_ff.lvl;
  assign edge_rise = s_ff.rise;

  a_sample_rate: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $changed(level_req) |-> $past(s_ff.tick) == LAST)
    else $error("level request changed between sample ticks");
endmodule : ppbl_irq_sampler
`default_nettype wire

// >>> sim/ppbl_ext_model.sv
// Purpose: External memory and slow device on the bus pins
// Assumes: Strobe enables high while a strobe is active
// Notes:   Released data bus shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module ppbl_ext_model (
  input  wire logic        clk_sys,
  input  wire logic        slow,
  input  wire logic [7:0]  rd_byte,
  input  wire logic        rd_oe,
  input  wire logic        wr_oe,
  input  wire logic [7:0]  db_out,
  input  wire logic        db_oe,
  input  wire logic [15:0] addr,
  input  wire logic        flag,
  output logic [7:0]       db_in,
  output logic             wait_n,
  output logic [7:0]       wr_seen,
  output logic [15:0]      addr_seen,
  output logic [15:0]      pair_seen,
  output logic [3:0]       rd_len,
  output logic [3:0]       flag_len
);
  logic [7:0] last_ff = 8'h00;
  logic       rd_d_ff = 1'b0;
  logic       flag_d_ff = 1'b0;
  logic [4:0] cnt_ff = 5'h1F;
  // Stale bus must never pass for read data
  assign db_in  = db_oe ? db_out : (rd_oe ? rd_byte : ~last_ff);
  // Slow device holds wait low until three strobe clocks have passed
  assign wait_n = !(slow && !(rd_oe && rd_len >= 4'h3));
  always @(posedge clk_sys) begin
    last_ff <= db_in;
    rd_d_ff <= rd_oe;
    flag_d_ff <= flag;
    if (rd_oe && !rd_d_ff) rd_len <= 4'h1;
    else if (rd_oe) rd_len <= rd_len + 4'h1;
    if (rd_oe) addr_seen <= addr;
    if (flag && !flag_d_ff) flag_len <= 4'h1;
    else if (flag) flag_len <= flag_len + 4'h1;
    if (wr_oe) wr_seen <= db_in;
    if (flag && !flag_d_ff) cnt_ff <= 5'h02;
    else if (cnt_ff != 5'h1F) cnt_ff <= cnt_ff + 5'h01;
    if (cnt_ff == 5'h09) pair_seen <= addr;
  end
endmodule : ppbl_ext_model
`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: Self-checking bench for the port and bus pin logic
// Assumes: AXI4-Lite master with response readies held high
// Notes:   Far side of the external bus is the model
`timescale 1ns/1ps
`default_nettype none
`include "ppbl_regs.svh"
module tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, irq_source;
  logic [7:0] output_port_pins, bidir_port_pins_in, bidir_port_pins_out, bidir_port_pins_oe;
  logic [7:0] ext_data_bus_in, ext_data_bus_out, wr_seen, pb_drv = 8'h96, rd_byte = 8'h5A;
  logic [5:0] input_port_pins = 6'h2A;
  logic [15:0] ext_address_bus, addr_seen, pair_seen;
  logic [3:0] rd_len, flag_len;
  logic wr_strobe_n_out, wr_strobe_n_oe, rd_strobe_n_out, rd_strobe_n_oe, timer_square_out;
  logic ext_data_bus_oe, first_fetch_cycle_flag, wait_request_n, irq_request;
  logic slow = 1'b0, level_irq_input = 1'b0, edge_irq_input = 1'b0;
  int bad_count = 0;
  int n_compared = 0;
  // Bench drives port B only where the port floats
  assign bidir_port_pins_in = (bidir_port_pins_oe & bidir_port_pins_out)
                            | (~bidir_port_pins_oe & pb_drv);
  ppbl_top uut (
    .clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .output_port_pins,
    .bidir_port_pins_in, .bidir_port_pins_out, .bidir_port_pins_oe, .input_port_pins,
    .wr_strobe_n_out, .wr_strobe_n_oe, .rd_strobe_n_out, .rd_strobe_n_oe, .timer_square_out,
    .ext_data_bus_in, .ext_data_bus_out, .ext_data_bus_oe, .ext_address_bus,
    .first_fetch_cycle_flag, .wait_request_n, .level_irq_input, .edge_irq_input,
    .irq_request, .irq_source);
  ppbl_ext_model ext (
    .clk_sys, .slow, .rd_byte, .rd_oe(rd_strobe_n_oe), .wr_oe(wr_strobe_n_oe),
    .db_out(ext_data_bus_out), .db_oe(ext_data_bus_oe), .addr(ext_address_bus),
    .flag(first_fetch_cycle_flag), .db_in(ext_data_bus_in), .wait_n(wait_request_n),
    .wr_seen, .addr_seen, .pair_seen, .rd_len, .flag_len);
  initial forever #25 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        done = 1'b1;
        resp = s_axi_bresp;
      end
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        done = 1'b1;
        rdat = s_axi_rdata;
      end
    end
  endtask : axi_rd
  // Polls busy, so the last read leaves the captured byte in rdat
  task automatic bus_cmd(input logic [31:0] c);
    axi_wr(`PPBL_OFF_CMD, c);
    rdat = 32'h1;
    while (rdat[0]) axi_rd(`PPBL_OFF_CMD);
  endtask : bus_cmd
  task automatic t_reset();
    repeat (8) @(posedge clk_sys);
    chk({output_port_pins, bidir_port_pins_oe}, 16'h0);
    chk({ext_data_bus_oe, timer_square_out, wr_strobe_n_oe}, 3'h0);
    reset_n <= 1'b1;
    axi_rd(`PPBL_OFF_PBDIR);
    chk(rdat[7:0], `PPBL_RST_PBDIR);
  endtask : t_reset
  task automatic t_ports();
    axi_wr(`PPBL_OFF_PORTA, 32'hC3);
    axi_wr(`PPBL_OFF_PBDIR, 32'h00);
    axi_wr(`PPBL_OFF_PORTB, 32'hA5);
    chk({bidir_port_pins_oe, bidir_port_pins_out}, 16'hFFA5);
    axi_wr(`PPBL_OFF_PBDIR, 32'hF0);
    chk(bidir_port_pins_oe, 8'h0F);
    axi_wr(`PPBL_OFF_PORTB, 32'h3C);
    axi_rd(`PPBL_OFF_PORTB);
    chk(rdat[7:0], 8'h9C);
    axi_wr(`PPBL_OFF_PBDIR, 32'h00);
    chk({bidir_port_pins_oe, bidir_port_pins_out}, 16'hFFAC);
    axi_rd(`PPBL_OFF_PORTB);
    chk(rdat[7:0], 8'hAC);
    chk(output_port_pins, 8'hC3);
    axi_rd(`PPBL_OFF_PORTC);
    chk(rdat[5:0], 6'h2A);
    axi_wr(8'h30, 32'h0);
    chk(resp, `PPBL_RESP_SLVERR);
  endtask : t_ports
  task automatic t_bus();
    axi_wr(`PPBL_OFF_ADDR, 32'h1234);
    bus_cmd(32'h1);
    chk({addr_seen, rdat[15:8]}, 24'h12345A);
    chk(rd_len, 4'h2);
    chk(ext_address_bus, 16'h0);
    slow <= 1'b1;
    rd_byte <= 8'hA7;
    bus_cmd(32'h1);
    chk({rd_len > 4'h2, rdat[15:8]}, 9'h1A7);
    slow <= 1'b0;
    axi_wr(`PPBL_OFF_ADDR, 32'h2000);
    axi_wr(`PPBL_OFF_WDATA, 32'h77);
    bus_cmd(32'h2);
    chk(wr_seen, 8'h77);
    bus_cmd(32'h3);
    chk({flag_len, addr_seen, rdat[15:8]}, 28'h32000A7);
    axi_wr(`PPBL_OFF_PAIR, 32'hBEEF);
    bus_cmd(32'h4);
    chk(pair_seen, 16'hBEEF);
  endtask : t_bus
  task automatic t_timer();
    time t0;
    axi_wr(`PPBL_OFF_CTRL, 32'h1);
    axi_wr(`PPBL_OFF_CMD, 32'h2);
    axi_rd(`PPBL_OFF_CMD);
    chk({ext_data_bus_oe, rdat[0]}, 2'h0);
    axi_wr(`PPBL_OFF_CTRL, 32'h0402);
    @(posedge timer_square_out);
    t0 = $time;
    @(posedge timer_square_out);
    chk(32'($time - t0), 32'(10 * `PPBL_CLK_NS));
    repeat (12) @(posedge clk_sys);
    chk({irq_request, irq_source}, 3'h6);
    axi_wr(`PPBL_OFF_CTRL, 32'h0);
    axi_wr(`PPBL_OFF_IRQ, 32'h2);
    chk({irq_request, irq_source}, 3'h0);
  endtask : t_timer
  task automatic t_irq();
    level_irq_input <= 1'b1;
    repeat (60) @(posedge clk_sys);
    chk({irq_request, irq_source}, 3'h5);
    edge_irq_input <= 1'b1;
    repeat (60) @(posedge clk_sys);
    chk(irq_source, 2'h1);
    level_irq_input <= 1'b0;
    repeat (60) @(posedge clk_sys);
    chk({irq_request, irq_source}, 3'h7);
    edge_irq_input <= 1'b0;
    axi_wr(`PPBL_OFF_IRQ, 32'h4);
    chk({irq_request, irq_source}, 3'h0);
  endtask : t_irq
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  // Whole run needs a few hundred clocks
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    end_sim();
  end
  initial begin
    t_reset();
    t_ports();
    t_bus();
    t_timer();
    t_irq();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
